// File: rtl/pll_holdover_config_regs.sv
/*
 * Register bank for PLL reference, holdover and zero-delay feedback control.
 * Assumes the serial control port gives a decoded address, a write strobe
 * with data, and a read strobe; read data appears one cycle after it.
 * Lock-detect comparator and sync inputs come from pins and are synchronised.
 * All outputs are registered, so each lags its register bit by one edge;
 * software sees a write on the outputs two edges after the strobe.
 */
module pll_holdover_config_regs
   import pll_holdover_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clock_enable,
   input wire logic [9:0] reg_address,
   input wire logic reg_write,
   input wire logic [7:0] reg_write_data,
   input wire logic reg_read,
   input wire logic [5:0] status_pin_select,
   input wire logic [5:0] status_select_field,
   input wire logic status_eeprom,
   input wire logic lock_detect_pin,
   input wire logic sync_pin,
   input wire logic auto_holdover_request,
   input wire logic [7:0] readback_live,
   output logic [7:0] reg_read_data,
   output logic reg_read_valid,
   output logic status_pin,
   output logic xtal_amp_enable,
   output logic doubler_enable,
   output logic [7:0] readback_status,
   output logic lock_detect_used,
   output logic holdover_active,
   output logic feedback_active,
   output logic [1:0] feedback_divider
);

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic [7:0] ref_holdover;
   logic [7:0] zero_delay;
   logic [7:0] next_ref_holdover;
   logic [7:0] next_zero_delay;

   always_comb begin
      next_ref_holdover = ref_holdover;
      next_zero_delay = zero_delay;
      if (reg_write && reg_address == ref_holdover_offset) begin
         next_ref_holdover = reg_write_data & ref_holdover_mask;
      end else if (reg_write && reg_address == zero_delay_offset) begin
         next_zero_delay = reg_write_data & zero_delay_mask;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ref_holdover <= ref_holdover_reset;
         zero_delay <= zero_delay_reset;
      end else if (clock_enable) begin
         ref_holdover <= next_ref_holdover;
         zero_delay <= next_zero_delay;
      end
   end

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   // Both pins are asynchronous; logic reads only the second stage
   logic [1:0] lock_detect_sync;
   logic [1:0] sync_pin_sync;
   logic [1:0] next_lock_detect_sync;
   logic [1:0] next_sync_pin_sync;

   always_comb begin
      next_lock_detect_sync = {lock_detect_sync[0], lock_detect_pin};
      next_sync_pin_sync = {sync_pin_sync[0], sync_pin};
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lock_detect_sync <= 2'b00;
         sync_pin_sync <= 2'b00;
      end else if (clock_enable) begin
         lock_detect_sync <= next_lock_detect_sync;
         sync_pin_sync <= next_sync_pin_sync;
      end
   end

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   pll_control_type pll_control;
   zero_delay_control_type zd_control;
   logic lock_detect_seen;

   pll_control_decode decode (
      .ref_holdover(ref_holdover),
      .zero_delay(zero_delay),
      .lock_detect_pin(lock_detect_sync[1]),
      .pll_control(pll_control),
      .zd_control(zd_control),
      .lock_detect_seen(lock_detect_seen)
   );

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   logic [7:0] next_read_data;
   logic next_read_valid;

   // Unmapped addresses still answer, with zero data
   always_comb begin
      next_read_data = 8'h00;
      next_read_valid = reg_read;
      if (reg_read && reg_address == ref_holdover_offset) begin
         next_read_data = ref_holdover;
      end else if (reg_read && reg_address == zero_delay_offset) begin
         next_read_data = zero_delay;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_read_data <= 8'h00;
         reg_read_valid <= 1'b0;
      end else if (clock_enable) begin
         reg_read_data <= next_read_data;
         reg_read_valid <= next_read_valid;
      end
   end

   // ----------------------------------------------------------------------
   // Status pin
   // ----------------------------------------------------------------------
   logic next_status_eeprom_selected;
   logic next_status_pin;

   always_comb begin
      next_status_eeprom_selected = pll_control.status_eeprom_select;
      // Pin selection field is ignored while EEPROM status owns the pin
      next_status_pin = next_status_eeprom_selected ?
         status_eeprom : status_pin_select[0];
      if (!next_status_eeprom_selected &&
          status_select_field == 6'h00) begin
         next_status_pin = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         status_pin <= 1'b0;
      end else if (clock_enable) begin
         status_pin <= next_status_pin;
      end
   end

   // ----------------------------------------------------------------------
   // Readback status
   // ----------------------------------------------------------------------
   logic [7:0] next_readback;

   // Frozen readback keeps its last value for software to inspect
   always_comb begin
      next_readback = pll_control.readback_refresh ?
         readback_live : readback_status;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         readback_status <= 8'h00;
      end else if (clock_enable) begin
         readback_status <= next_readback;
      end
   end

   // ----------------------------------------------------------------------
   // PLL and holdover controls
   // ----------------------------------------------------------------------
   logic next_xtal_amp;
   logic next_doubler;
   logic next_lock_detect_used;
   logic next_holdover;
   logic next_feedback_active;
   logic [1:0] next_feedback_divider;

   always_comb begin
      next_xtal_amp = pll_control.xtal_amp_enable;
      next_doubler = pll_control.doubler_enable;
      next_lock_detect_used = pll_control.lock_detect_used;
      next_feedback_active = zd_control.feedback_active;
      // Divider code is shown even while the path is idle
      next_feedback_divider = zd_control.feedback_divider;
      case (pll_control.holdover_mode)
         holdover_external_type: next_holdover = sync_pin_sync[1];
         holdover_auto_type:
            next_holdover = auto_holdover_request &&
               lock_detect_seen;
         default: next_holdover = 1'b0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         xtal_amp_enable <= 1'b0;
         doubler_enable <= 1'b0;
         lock_detect_used <= 1'b0;
         holdover_active <= 1'b0;
         feedback_active <= 1'b0;
         feedback_divider <= 2'b00;
      end else if (clock_enable) begin
         xtal_amp_enable <= next_xtal_amp;
         doubler_enable <= next_doubler;
         lock_detect_used <= next_lock_detect_used;
         holdover_active <= next_holdover;
         feedback_active <= next_feedback_active;
         feedback_divider <= next_feedback_divider;
      end
   end

endmodule

// File: rtl/pll_holdover_pkg.sv
/*
 * Constants, field positions and carrier types for the PLL reference and
 * holdover configuration bank (registers pll_reference_holdover_control and zero_delay_feedback_control).
 * Assumes a byte-wide serial control port decodes a register address and
 * hands this bank write strobes and read requests on the system clock.
 */
// What this block does
// - Bit 7 of pll_reference_holdover_control, set at reset, routes EEPROM status to the status pin.
// - Bit 6 of pll_reference_holdover_control powers the crystal maintaining amplifier; off at reset.
// - Bit 5 of pll_reference_holdover_control enables the reference doubler; bypassed at reset.
// - Bit 4 of pll_reference_holdover_control freezes automatic refresh of readback register 0x01f.
// - Bit 3 clear makes holdover see the lock-detect pin as true.
// - Bit 1 of pll_reference_holdover_control hands holdover to the sync pin, disabling automatic.
// - Bit 0 of pll_reference_holdover_control enables internal holdover; disabled at reset.
// - Field [4:3] of zero_delay_feedback_control picks feedback channel divider 0 to 3.
// - Divider pick is output in every mode; feedback is active only with zero delay and external mode both set.
package pll_holdover_pkg;

   localparam logic [9:0] ref_holdover_offset = 10'h01d;
   localparam logic [9:0] zero_delay_offset = 10'h01e;

   // Field positions of register pll_reference_holdover_control
   localparam int status_eeprom_bit = 7;
   localparam int xtal_amp_bit = 6;
   localparam int doubler_bit = 5;
   localparam int readback_freeze_bit = 4;
   localparam int lock_compare_bit = 3;
   localparam int ext_holdover_bit = 1;
   localparam int holdover_enable_bit = 0;

   // Field positions of register zero_delay_feedback_control
   localparam int fb_select_lsb = 3;
   localparam int fb_select_msb = 4;
   localparam int ext_zero_delay_bit = 2;
   localparam int zero_delay_bit = 1;

   localparam logic [7:0] ref_holdover_reset = 8'h80;
   localparam logic [7:0] zero_delay_reset = 8'h00;
   localparam logic [7:0] ref_holdover_mask = 8'hfb;
   localparam logic [7:0] zero_delay_mask = 8'h1e;

   typedef enum logic [1:0] {
      holdover_off_type = 2'b00,
      holdover_auto_type = 2'b01,
      holdover_external_type = 2'b11
   } holdover_mode_type;

   typedef struct packed {
      logic status_eeprom_select;
      logic xtal_amp_enable;
      logic doubler_enable;
      logic readback_refresh;
      logic lock_detect_used;
      holdover_mode_type holdover_mode;
   } pll_control_type;

   typedef struct packed {
      logic feedback_active;
      logic [1:0] feedback_divider;
   } zero_delay_control_type;

endpackage

// File: rtl/pll_control_decode.sv
/*
 * Turns the two stored register bytes into the control signals that the
 * analog PLL, holdover controller and zero-delay path use.
 * Assumes its inputs are register outputs on the same clock.
 */
module pll_control_decode
   import pll_holdover_pkg::*;
(
   input wire logic [7:0] ref_holdover,
   input wire logic [7:0] zero_delay,
   input wire logic lock_detect_pin,
   output pll_control_type pll_control,
   output zero_delay_control_type zd_control,
   output logic lock_detect_seen
);

   always_comb begin
      pll_control.status_eeprom_select =
         ref_holdover[status_eeprom_bit];
      pll_control.xtal_amp_enable = ref_holdover[xtal_amp_bit];
      pll_control.doubler_enable = ref_holdover[doubler_bit];
      pll_control.readback_refresh =
         !ref_holdover[readback_freeze_bit];
      pll_control.lock_detect_used = ref_holdover[lock_compare_bit];
      // External control wins over the internal enable
      if (ref_holdover[ext_holdover_bit]) begin
         pll_control.holdover_mode = holdover_external_type;
      end else if (ref_holdover[holdover_enable_bit]) begin
         pll_control.holdover_mode = holdover_auto_type;
      end else begin
         pll_control.holdover_mode = holdover_off_type;
      end
      // Comparator off means the pin counts as locked
      lock_detect_seen = ref_holdover[lock_compare_bit] ?
         lock_detect_pin : 1'b1;
      zd_control.feedback_active = zero_delay[zero_delay_bit] &&
         zero_delay[ext_zero_delay_bit];
      zd_control.feedback_divider =
         zero_delay[fb_select_msb:fb_select_lsb];
   end

endmodule

// File: verif/pll_holdover_config_regs_asserts.sv
/* Port assertions for the PLL holdover register bank.
   Bound from the bench top; sees only the top module ports. */
module pll_holdover_config_regs_asserts
   import pll_holdover_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clock_enable,
   input wire logic [9:0] reg_address,
   input wire logic reg_read,
   input wire logic sync_pin,
   input wire logic status_eeprom,
   input wire logic [7:0] readback_live,
   input wire logic [7:0] reg_read_data,
   input wire logic reg_read_valid,
   input wire logic status_pin,
   input wire logic xtal_amp_enable,
   input wire logic doubler_enable,
   input wire logic [7:0] readback_status,
   input wire logic lock_detect_used,
   input wire logic holdover_active,
   input wire logic feedback_active,
   input wire logic [1:0] feedback_divider
);
   timeunit 1ns;
   timeprecision 1ps;
   // Read data and outputs come from the same register snapshot
   wire logic take = reg_read && clock_enable;
   wire logic rd_a = take && reg_address == ref_holdover_offset;
   wire logic rd_b = take && reg_address == zero_delay_offset;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   read_valid_a: assert property (take |=> reg_read_valid)
      else $error("read valid missing");
   spare_bits_a: assert property (rd_a |=> !reg_read_data[2])
      else $error("spare bit of 0x1d read set");
   spare_top_a: assert property (rd_b |=> reg_read_data[7:5] == 3'h0)
      else $error("spare bits of 0x1e read set");
   status_eeprom_a: assert property (
      rd_a ##1 reg_read_data[7] |-> status_pin == $past(status_eeprom))
      else $error("status pin not following eeprom");
   xtal_amp_a: assert property (
      rd_a |=> xtal_amp_enable == reg_read_data[6])
      else $error("crystal amplifier mismatch");
   ref_doubler_a: assert property (
      rd_a |=> doubler_enable == reg_read_data[5])
      else $error("doubler mismatch");
   readback_live_a: assert property (
      rd_a ##1 !reg_read_data[4] |-> readback_status == $past(readback_live))
      else $error("readback not refreshed");
   lock_used_a: assert property (
      rd_a |=> lock_detect_used == reg_read_data[3])
      else $error("lock detect use mismatch");
   holdover_off_a: assert property (
      rd_a ##1 reg_read_data[1:0] == 2'h0 |-> !holdover_active)
      else $error("holdover active while disabled");
   // Sync pin needs two synchroniser edges plus the output edge
   sync_follow_a: assert property (
      rd_a ##1 (reg_read_data[1] && $past(clock_enable, 2) &&
      $past(clock_enable, 3)) |-> holdover_active == $past(sync_pin, 3))
      else $error("holdover not following sync pin");
   fb_divider_a: assert property (
      rd_b |=> feedback_divider == reg_read_data[4:3])
      else $error("feedback divider mismatch");
   fb_active_a: assert property (
      rd_b |=> feedback_active == (reg_read_data[2] && reg_read_data[1]))
      else $error("feedback active mismatch");
   cover property (rd_a ##1 reg_read_data[1]);
   cover property (holdover_active);
   cover property (feedback_active);
endmodule

// File: verif/pll_holdover_config_regs_test.sv
/* Self-checking bench for the PLL holdover register bank.
   Drives every port directly; no partner model is needed. */
module pll_holdover_config_regs_test
   import pll_holdover_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, sys_rst = 1, clock_enable = 1, reg_write = 0;
   logic reg_read = 0, status_eeprom = 0, lock_detect_pin = 0;
   logic sync_pin = 0, auto_holdover_request = 0, reg_read_valid;
   logic [9:0] reg_address = 10'h000;
   logic [7:0] reg_write_data = 8'h00, readback_live = 8'h00;
   logic [5:0] status_pin_select = 6'h00, status_select_field = 6'h00;
   logic [7:0] reg_read_data, readback_status;
   logic status_pin, xtal_amp_enable, doubler_enable, lock_detect_used;
   logic holdover_active, feedback_active;
   logic [1:0] feedback_divider;
   int fail_count = 0;
   int checks_done = 0;
   pll_holdover_config_regs DUT (.clock, .sys_rst, .clock_enable,
      .reg_address, .reg_write, .reg_write_data, .reg_read,
      .status_pin_select, .status_select_field, .status_eeprom,
      .lock_detect_pin, .sync_pin, .auto_holdover_request, .readback_live,
      .reg_read_data, .reg_read_valid, .status_pin, .xtal_amp_enable,
      .doubler_enable, .readback_status, .lock_detect_used,
      .holdover_active, .feedback_active, .feedback_divider);
   // ----------------------------------------
   // Bus helpers
   // ----------------------------------------
   task tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task chk(input string name, input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Waits two edges so derived outputs have settled
   task wr(input logic [9:0] a, input logic [7:0] d);
      reg_address = a;
      reg_write_data = d;
      reg_write = 1;
      tick(1);
      reg_write = 0;
      tick(2);
   endtask
   task rd(input logic [9:0] a, input logic [7:0] exp);
      reg_address = a;
      reg_read = 1;
      tick(1);
      reg_read = 0;
      chk("read valid", 8'(reg_read_valid), 8'h01);
      chk("read data", reg_read_data, exp);
      tick(1);
      chk("valid drop", 8'(reg_read_valid), 8'h00);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task test_reset;
      rd(10'h01d, 8'h80);
      rd(10'h01e, 8'h00);
      chk("amp", 8'(xtal_amp_enable), 8'h00);
      chk("dbl", 8'(doubler_enable), 8'h00);
      chk("hold", 8'(holdover_active), 8'h00);
   endtask
   task test_status;
      status_eeprom = 1;
      status_pin_select = 6'h00;
      status_select_field = 6'h01;
      tick(2);
      chk("pin eeprom", 8'(status_pin), 8'h01);
      status_eeprom = 0;
      status_pin_select = 6'h01;
      tick(2);
      chk("pin eeprom low", 8'(status_pin), 8'h00);
      status_pin_select = 6'h00;
      status_eeprom = 1;
      wr(10'h01d, 8'h00);
      chk("pin field", 8'(status_pin), 8'h00);
      status_pin_select = 6'h01;
      tick(2);
      chk("pin sel", 8'(status_pin), 8'h01);
      status_select_field = 6'h00;
      tick(2);
      chk("pin field off", 8'(status_pin), 8'h00);
   endtask
   task test_bits;
      wr(10'h01d, 8'hff);
      rd(10'h01d, 8'hfb);
      chk("amp", 8'(xtal_amp_enable), 8'h01);
      chk("dbl", 8'(doubler_enable), 8'h01);
      chk("lock used", 8'(lock_detect_used), 8'h01);
      readback_live = 8'h5a;
      tick(2);
      chk("frozen", readback_status, 8'h00);
      wr(10'h01d, 8'h00);
      chk("live", readback_status, 8'h5a);
   endtask
   // Pins pass a two-stage synchroniser and the output register, three edges; four are waited
   task test_holdover;
      wr(10'h01d, 8'h01);
      chk("auto idle", 8'(holdover_active), 8'h00);
      auto_holdover_request = 1;
      tick(2);
      chk("auto", 8'(holdover_active), 8'h01);
      wr(10'h01d, 8'h09);
      tick(2);
      chk("lock low", 8'(holdover_active), 8'h00);
      lock_detect_pin = 1;
      tick(4);
      chk("lock high", 8'(holdover_active), 8'h01);
      wr(10'h01d, 8'h03);
      tick(2);
      chk("sync low", 8'(holdover_active), 8'h00);
      sync_pin = 1;
      tick(4);
      chk("sync high", 8'(holdover_active), 8'h01);
      rd(10'h01d, 8'h03);
      wr(10'h01d, 8'h00);
      chk("off", 8'(holdover_active), 8'h00);
   endtask
   task test_feedback;
      for (int c = 0; c < 4; c++) begin
         wr(10'h01e, {3'h0, c[1:0], 3'h6});
         chk("fb on", 8'(feedback_active), 8'h01);
         chk("fb div", 8'(feedback_divider), 8'(c));
      end
      wr(10'h01e, 8'hff);
      rd(10'h01e, 8'h1e);
      wr(10'h01e, 8'h1a);
      chk("fb int", 8'(feedback_active), 8'h00);
      wr(10'h01e, 8'h1c);
      chk("fb off", 8'(feedback_active), 8'h00);
   endtask
   task test_refused;
      clock_enable = 0;
      wr(10'h01e, 8'h18);
      clock_enable = 1;
      rd(10'h01e, 8'h1c);
      wr(10'h01c, 8'hff);
      rd(10'h01c, 8'h00);
   endtask
   // Mid-run reset restores the defaults
   task test_again;
      sys_rst = 1;
      tick(2);
      sys_rst = 0;
      chk("fb rst", 8'(feedback_divider), 8'h00);
      rd(10'h01d, 8'h80);
      rd(10'h01e, 8'h00);
   endtask
   task give_verdict;
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial forever #5 clock = ~clock;
   initial begin
      tick(10);
      sys_rst = 0;
      test_reset;
      test_status;
      test_bits;
      test_holdover;
      test_feedback;
      test_refused;
      test_again;
      give_verdict;
   end
   // Whole run needs about a hundred cycles
   initial begin
      repeat (5000) @(posedge clock);
      fail_count++;
      give_verdict;
   end
endmodule
bind pll_holdover_config_regs pll_holdover_config_regs_asserts chk_i (
   .clock(clock), .sys_rst(sys_rst), .clock_enable(clock_enable),
   .reg_address(reg_address), .reg_read(reg_read), .sync_pin(sync_pin),
   .status_eeprom(status_eeprom), .readback_live(readback_live),
   .reg_read_data(reg_read_data), .reg_read_valid(reg_read_valid),
   .status_pin(status_pin), .xtal_amp_enable(xtal_amp_enable),
   .doubler_enable(doubler_enable), .readback_status(readback_status),
   .lock_detect_used(lock_detect_used), .holdover_active(holdover_active),
   .feedback_active(feedback_active), .feedback_divider(feedback_divider));
